// ==== rtl/status_out_pkg.sv ====
// shared constants for the servo status output block
package status_out_pkg;
    // rotation threshold range and default, in 1 min-1 units
    localparam int          SPEED_W        = 16;
    localparam logic [15:0] ROT_THR_MIN    = 16'h0001;
    localparam logic [15:0] ROT_THR_MAX    = 16'h2710;
    localparam logic [15:0] ROT_THR_RESET  = 16'h0014;
    // terminal selection
    localparam int          TERM_COUNT     = 4;
    localparam int          SEL_W          = 3;
    localparam logic [2:0]  SEL_NONE       = 3'h0;
    localparam logic [2:0]  WARN_SEL_RESET = 3'h3;
    localparam logic [2:0]  ROT_SEL_RESET  = 3'h2;
    localparam logic [2:0]  RDY_SEL_RESET  = 3'h1;
    // absolute data send length in cycles; no logic uses it as a timeout
    localparam int          ABS_SEND_CYC   = 4;
endpackage

// ==== rtl/term_router.sv ====
// routes three active status levels onto selectable output terminals
`timescale 1ns/1ps
`default_nettype none
module term_router
    import status_out_pkg::*;
#(
    parameter int TERMS = TERM_COUNT
) (
    // status levels, high means closed
    input  wire logic             warn_on,
    input  wire logic             rot_on,
    input  wire logic             rdy_on,
    // terminal selections, 0 means unassigned
    input  wire logic [SEL_W-1:0] warn_sel,
    input  wire logic [SEL_W-1:0] rot_sel,
    input  wire logic [SEL_W-1:0] rdy_sel,
    // terminal closed levels
    output logic      [TERMS-1:0] term_closed
);
    // one-hot decode; selection 1 is terminal 0
    function automatic logic [TERMS-1:0] dec(input logic [SEL_W-1:0] s);
        logic [TERMS-1:0] v;
        v = '0;
        for (int i = 0; i < TERMS; i++) begin
            if (s == SEL_W'(i + 1)) begin
                v[i] = 1'b1;
            end
        end
        return v;
    endfunction

    // several signals on one terminal are or-ed so none is hidden
    always_comb begin
        term_closed = ({TERMS{warn_on}} & dec(warn_sel))
                    | ({TERMS{rot_on}} & dec(rot_sel))
                    | ({TERMS{rdy_on}} & dec(rdy_sel));
    end
endmodule
`default_nettype wire

// ==== rtl/servo_status_outputs.sv ====
// servo drive status outputs: warning, rotation detect, servo ready
//
// Overview of operation
// - warning output closed while a warning exists, open otherwise.
// - warning output routed to terminal chosen by warn_terminal_select.
// - rotation-detect closed when speed magnitude exceeds the threshold.
// - rotation-detect open while speed is below the threshold.
// - rotation-detect routed to terminal chosen by rotation_terminal_select.
// - servo-ready relates to accepting a servo-on request.
// - servo-ready needs main power present and no active alarm.
// - absolute encoder: ready only after data sent following sensor enable.
// - servo-ready closed when servo-on can be accepted, open when not.
// - servo-ready routed to terminal chosen by ready_terminal_select.
`timescale 1ns/1ps
`default_nettype none
module servo_status_outputs
    import status_out_pkg::*;
#(
    parameter int TERMS = TERM_COUNT
) (
    // clock and reset
    input  wire logic               sys_clk,
    input  wire logic               rstn,
    // drive state from on-chip logic
    input  wire logic               warning_active,
    input  wire logic               alarm_active,
    input  wire logic               main_power_on,
    input  wire logic signed [SPEED_W-1:0] motor_speed,
    // configuration
    input  wire logic [SPEED_W-1:0] rotation_speed_threshold,
    input  wire logic [SEL_W-1:0]   warn_terminal_select,
    input  wire logic [SEL_W-1:0]   rotation_terminal_select,
    input  wire logic [SEL_W-1:0]   ready_terminal_select,
    input  wire logic               abs_encoder_used,
    // absolute data transfer toward the controller
    input  wire logic               abs_data_request_in,
    output logic                    abs_send_start,
    input  wire logic               abs_send_done,
    // status levels and terminals
    output logic                    warn_out,
    output logic                    rotation_detect_out,
    output logic                    servo_ready_out,
    output logic                    thr_out_of_range,
    output logic      [TERMS-1:0]   term_closed
);
    typedef enum logic [1:0] {ABS_IDLE, ABS_SEND, ABS_DONE} abs_state_t;

    // threshold outside its legal span
    function automatic logic thr_illegal(input logic [SPEED_W-1:0] t);
        return (t < ROT_THR_MIN) || (t > ROT_THR_MAX);
    endfunction

    // nearest legal threshold, so a bad setting still acts sanely
    function automatic logic [SPEED_W-1:0] thr_clamp(
        input logic [SPEED_W-1:0] t
    );
        logic [SPEED_W-1:0] c;
        c = t;
        if (t < ROT_THR_MIN) begin
            c = ROT_THR_MIN;
        end else if (t > ROT_THR_MAX) begin
            c = ROT_THR_MAX;
        end
        return c;
    endfunction

    // speed magnitude; the most negative code keeps its own pattern
    function automatic logic [SPEED_W-1:0] speed_mag(
        input logic signed [SPEED_W-1:0] s
    );
        logic [SPEED_W-1:0] m;
        m = SPEED_W'(s);
        if (s[SPEED_W-1]) begin
            m = SPEED_W'(-s);
        end
        return m;
    endfunction

    // pin synchroniser for the sensor-enable input
    logic sen_meta_ff;
    logic sen_sync_ff;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sen_meta_ff <= 1'b0;
            sen_sync_ff <= 1'b0;
        end else begin
            sen_meta_ff <= abs_data_request_in;
            sen_sync_ff <= sen_meta_ff;
        end
    end

    // threshold clamped into its legal range, applied at once
    logic [SPEED_W-1:0] thr_eff;
    always_comb begin
        thr_eff = thr_clamp(rotation_speed_threshold);
    end

    // magnitude so either direction counts as rotation
    logic [SPEED_W-1:0] speed_abs;
    always_comb begin
        speed_abs = speed_mag(motor_speed);
    end

    // absolute data send sequence after sensor enable rises
    abs_state_t abs_state_ff;
    abs_state_t nxt_abs_state;
    always_comb begin
        nxt_abs_state = abs_state_ff;
        unique case (abs_state_ff)
            ABS_IDLE: begin
                if (sen_sync_ff) begin
                    nxt_abs_state = ABS_SEND;
                end
            end
            ABS_SEND: begin
                if (!sen_sync_ff) begin
                    nxt_abs_state = ABS_IDLE;
                end else if (abs_send_done) begin
                    nxt_abs_state = ABS_DONE;
                end
            end
            ABS_DONE: begin
                if (!sen_sync_ff) begin
                    nxt_abs_state = ABS_IDLE;
                end
            end
            // unused code: fall back to idle, ready stays low while an absolute encoder is used
            default: begin
                nxt_abs_state = ABS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            abs_state_ff <= ABS_IDLE;
        end else begin
            abs_state_ff <= nxt_abs_state;
        end
    end

    // one-cycle start pulse on entry to the send state
    logic start_ff;
    logic nxt_start;
    always_comb begin
        nxt_start = (abs_state_ff == ABS_IDLE)
                  && (nxt_abs_state == ABS_SEND);
    end

    // registered so the sender sees a clean strobe
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            start_ff <= 1'b0;
        end else begin
            start_ff <= nxt_start;
        end
    end

    assign abs_send_start = start_ff;

    // absolute data gate, open at once without an absolute encoder
    logic abs_ok;
    always_comb begin
        abs_ok = !abs_encoder_used || (abs_state_ff == ABS_DONE);
    end

    // warning level: closed while a warning stands
    logic warn_ff;
    logic nxt_warn;
    always_comb begin
        nxt_warn = warning_active;
    end

    // status levels follow their inputs one cycle later and hold while they stand
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            warn_ff <= 1'b0;
        end else begin
            warn_ff <= nxt_warn;
        end
    end

    assign warn_out = warn_ff;

    // rotation level: strictly above the threshold, equal stays open
    logic rot_ff;
    logic nxt_rot;
    always_comb begin
        nxt_rot = 1'b0;
        if (speed_abs > thr_eff) begin
            nxt_rot = 1'b1;
        end
    end

    // new threshold acts on the very next edge
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rot_ff <= 1'b0;
        end else begin
            rot_ff <= nxt_rot;
        end
    end

    assign rotation_detect_out = rot_ff;

    // ready level: power, no alarm and, if needed, absolute data sent
    logic ready_ff;
    logic nxt_ready;
    always_comb begin
        nxt_ready = 1'b0;
        if (main_power_on && !alarm_active) begin
            nxt_ready = abs_ok;
        end
    end

    // servo-on itself is not needed, ready says it could be taken
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ready_ff <= 1'b0;
        end else begin
            ready_ff <= nxt_ready;
        end
    end

    assign servo_ready_out = ready_ff;

    // range flag: the setting is clamped, this tells the user so
    logic range_ff;
    logic nxt_range;
    always_comb begin
        nxt_range = thr_illegal(rotation_speed_threshold);
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            range_ff <= 1'b0;
        end else begin
            range_ff <= nxt_range;
        end
    end

    assign thr_out_of_range = range_ff;

    // terminal assignment
    term_router #(
        .TERMS       (TERMS)
    ) u_router (
        .warn_on     (warn_out),
        .rot_on      (rotation_detect_out),
        .rdy_on      (servo_ready_out),
        .warn_sel    (warn_terminal_select),
        .rot_sel     (rotation_terminal_select),
        .rdy_sel     (ready_terminal_select),
        .term_closed (term_closed)
    );
endmodule
`default_nettype wire

// ==== verif/servo_status_chk.sv ====
// assertions on the servo status output ports
`timescale 1ns/1ps
`default_nettype none
module servo_status_chk
    import status_out_pkg::*;
#(parameter int TERMS = TERM_COUNT) (
    // watched ports
    input wire logic sys_clk, rstn, warning_active, alarm_active,
    input wire logic main_power_on, abs_encoder_used, abs_data_request_in,
    input wire logic signed [SPEED_W-1:0] motor_speed,
    input wire logic [SPEED_W-1:0] rotation_speed_threshold,
    input wire logic [SEL_W-1:0] warn_terminal_select,
    input wire logic [SEL_W-1:0] rotation_terminal_select,
    input wire logic [SEL_W-1:0] ready_terminal_select,
    input wire logic abs_send_start, warn_out, rotation_detect_out,
    input wire logic servo_ready_out,
    input wire logic [TERMS-1:0] term_closed
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // only legal thresholds are compared, clamping is judged by the bench
    wire logic signed [16:0] thr = $signed({1'b0, rotation_speed_threshold});
    wire logic thr_ok = rotation_speed_threshold inside {[1:10000]};
    sequence s_req; $rose(abs_data_request_in) && abs_encoder_used; endsequence
    // six cycles leave room for the two sync flops and the state step
    sequence s_idle; (abs_encoder_used && !abs_data_request_in) [*6]; endsequence
    AST_WARN: assert property (1 |=> warn_out == $past(warning_active))
        else $error("warning level wrong");
    AST_ROT_ON: assert property (thr_ok && motor_speed > thr |=>
        rotation_detect_out) else $error("rotation not detected");
    AST_ROT_OFF: assert property (thr_ok && motor_speed >= 0 &&
        motor_speed <= thr |=> !rotation_detect_out) else $error("false rotation");
    AST_RDY_OFF: assert property (!main_power_on || alarm_active |=>
        !servo_ready_out) else $error("ready without power or with alarm");
    AST_RDY_ON: assert property (!abs_encoder_used && main_power_on &&
        !alarm_active |=> servo_ready_out) else $error("ready missing");
    AST_START: assert property (s_req |-> ##[1:4] abs_send_start)
        else $error("absolute send not started");
    AST_RDY_ABS: assert property (s_idle |=> !servo_ready_out)
        else $error("ready without absolute data");
    AST_WARN_TERM: assert property (warn_terminal_select inside {[1:4]} &&
        warn_out |-> term_closed[warn_terminal_select-3'h1])
        else $error("warning terminal open");
    AST_ROT_TERM: assert property (rotation_terminal_select inside {[1:4]} &&
        rotation_detect_out |-> term_closed[rotation_terminal_select-3'h1])
        else $error("rotation terminal open");
    AST_RDY_TERM: assert property (ready_terminal_select inside {[1:4]} &&
        servo_ready_out |-> term_closed[ready_terminal_select-3'h1])
        else $error("ready terminal open");
endmodule
bind servo_status_outputs servo_status_chk #(.TERMS(TERMS)) u_chk (.*);
`default_nettype wire

// ==== verif/ctl_model.sv ====
// upper controller: raises sensor enable, answers the data send
`timescale 1ns/1ps
`default_nettype none
module ctl_model (
    // clock, reset and bench control
    input  wire logic       sys_clk, rstn, sen_want,
    input  wire logic [3:0] dly,
    // absolute data exchange
    input  wire logic       abs_send_start,
    output logic            abs_data_request_in, abs_send_done
);
    logic [3:0] cnt_ff;
    logic       busy_ff;
    assign abs_data_request_in = sen_want;
    // done pulse dly+1 cycles after the start is seen, so slow answers can be exercised
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            {busy_ff, cnt_ff, abs_send_done} <= '0;
        end else begin
            abs_send_done <= busy_ff && cnt_ff == 4'h0;
            if (abs_send_start) {busy_ff, cnt_ff} <= {1'b1, dly};
            else if (cnt_ff != 4'h0) cnt_ff <= cnt_ff - 4'h1;
            else busy_ff <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== verif/servo_status_outputs_tb.sv ====
// self-checking bench for the servo status outputs
`timescale 1ns/1ps
`default_nettype none
module servo_status_outputs_tb
    import status_out_pkg::*;
;
    logic sys_clk = 0, rstn = 0, warning_active = 0, alarm_active = 0;
    logic main_power_on = 0, abs_encoder_used = 0, sen_want = 0;
    logic signed [SPEED_W-1:0] motor_speed = '0;
    logic [SPEED_W-1:0] rotation_speed_threshold = ROT_THR_RESET;
    logic [SEL_W-1:0] warn_terminal_select = WARN_SEL_RESET;
    logic [SEL_W-1:0] rotation_terminal_select = ROT_SEL_RESET;
    logic [SEL_W-1:0] ready_terminal_select = RDY_SEL_RESET;
    logic [3:0] dly = 4'h5;
    logic abs_data_request_in, abs_send_start, abs_send_done, warn_out;
    logic rotation_detect_out, servo_ready_out, thr_out_of_range;
    logic [TERM_COUNT-1:0] term_closed;
    int errors = 0, compares = 0;
    servo_status_outputs u_servo_status_outputs (.*);
    ctl_model u_ctl_model (.*);
    initial forever #10 sys_clk = ~sys_clk;
    task automatic chk(input logic [15:0] got, exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic wrap_up;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic t_warn;
        warning_active = 1; step(2);
        chk(warn_out, 1);
        chk(term_closed[2], 1);
        warning_active = 0; step(2);
        chk(warn_out, 0);
    endtask
    // equal to threshold stays open, either direction counts
    task automatic t_rot;
        motor_speed = 16'sh0015; step(2);
        chk(rotation_detect_out, 1);
        chk(term_closed[1], 1);
        motor_speed = 16'sh0014; step(2);
        chk(rotation_detect_out, 0);
        motor_speed = -16'sh0015; step(2);
        chk(rotation_detect_out, 1);
        rotation_speed_threshold = ROT_THR_MAX + 16'h1;
        motor_speed = $signed(ROT_THR_MAX); step(2);
        chk({thr_out_of_range, rotation_detect_out}, 2);
        rotation_speed_threshold = 16'h0000; motor_speed = 16'sh0002; step(2);
        chk({thr_out_of_range, rotation_detect_out}, 3);
        rotation_speed_threshold = ROT_THR_RESET; motor_speed = '0;
    endtask
    task automatic t_rdy;
        main_power_on = 1; step(2);
        chk(servo_ready_out, 1);
        chk(term_closed[0], 1);
        alarm_active = 1; step(2);
        chk(servo_ready_out, 0);
        alarm_active = 0; main_power_on = 0; step(2);
        chk(servo_ready_out, 0);
    endtask
    // mid-run reset clears the warning output and the terminals at once
    task automatic t_reset;
        warning_active = 1; step(2);
        rstn = 0; step(1);
        chk({warn_out, term_closed}, 5'h00);
        rstn = 1; step(2);
        chk(warn_out, 1);
        warning_active = 0; step(2);
    endtask
    // terminal 3, unassigned codes, shared terminal
    task automatic t_term;
        warning_active = 1; warn_terminal_select = 3'h4; step(2);
        chk(term_closed, 4'h8);
        warn_terminal_select = 3'h0; step(1);
        chk(term_closed, 4'h0);
        motor_speed = 16'sh0100; rotation_terminal_select = 3'h4;
        warn_terminal_select = 3'h4; warning_active = 0; step(2);
        chk(term_closed, 4'h8);
        main_power_on = 1; ready_terminal_select = 3'h7; step(2);
        chk({servo_ready_out, term_closed}, 5'h18);
        ready_terminal_select = 3'h4; motor_speed = '0; step(2);
        chk(term_closed, 4'h8);
        main_power_on = 0; step(2);
        chk(term_closed, 4'h0);
        warn_terminal_select = WARN_SEL_RESET;
        rotation_terminal_select = ROT_SEL_RESET;
        ready_terminal_select = RDY_SEL_RESET;
    endtask
    // slow partner answer, ready must wait for the send to finish
    task automatic t_abs;
        int n;
        main_power_on = 1; abs_encoder_used = 1; step(8);
        chk(servo_ready_out, 0);
        sen_want = 1;
        for (n = 0; n < 40 && servo_ready_out !== 1'b1; n++) step(1);
        chk(n > 8, 1);
        chk(servo_ready_out, 1);
        sen_want = 0; step(8);
        chk(servo_ready_out, 0);
    endtask
    initial begin
        step(10); rstn = 1; step(2);
        t_warn; t_reset; t_rot; t_rdy; t_term; t_abs;
        wrap_up;
    end
    initial begin
        repeat (3000) @(posedge sys_clk);
        errors++;
        wrap_up;
    end
endmodule
`default_nettype wire
